//--- logic/lcfl_channel.sv
`default_nettype none

// one channel: fault flags, latch-off, loop control, gate and calibration
module lcfl_channel
(
    input wire logic i_clk,
    input wire logic i_resetn,
    lcfl_chan_if.chan bus,
    input wire logic i_short_event,
    input wire logic i_open_event,
    input wire logic i_ov_event,
    input wire logic i_oc_event,
    input wire logic i_boost_mode,
    input wire logic i_dimming_input_pin,
    input wire logic i_clear_latch_command,
    output logic o_gate_enable,
    output logic o_auto_calibration_select,
    output logic o_calibration_start
);
    logic shorted_load_flag;
    logic open_load_flag;
    logic overvoltage_flag;
    logic overcurrent_flag;
    logic overvoltage_latch_off_enable;
    logic auto_calibration_select;
    logic gate_reg;
    logic ov_latched;
    logic calibration_start;

    ////////////////////////////////////////////////////////////////
    // next values; a new event wins over the read clear
    wire logic next_short = i_short_event | (shorted_load_flag & ~bus.rd_fault);
    wire logic next_open = i_open_event | (open_load_flag & ~bus.rd_fault);
    wire logic next_oc = i_oc_event | (overcurrent_flag & ~bus.rd_fault);
    // with latch-off the flag ignores reads and waits for clear-latch
    wire logic ov_hold = overvoltage_latch_off_enable ? ~i_clear_latch_command : ~bus.rd_fault;
    wire logic next_ov = i_ov_event | (overvoltage_flag & ov_hold);
    wire logic next_latched = overvoltage_latch_off_enable
        & (i_ov_event | (ov_latched & ~i_clear_latch_command));
    wire logic wr_latch = bus.wdata[lcfl_pkg::lcfl_fault_latch_bit];
    wire logic wr_autocal = bus.wdata[lcfl_pkg::lcfl_loop_autocal_bit];
    wire logic wr_start = bus.wdata[lcfl_pkg::lcfl_loop_calstart_bit];
    wire logic wr_gate = bus.wdata[lcfl_pkg::lcfl_loop_gate_bit];
    // the start is honoured only when the same write selects the auto source
    wire logic start_ok = bus.wr_loop & wr_start & wr_autocal;
    // gate drive; an overvoltage event or latch blocks it; restart is automatic without latch-off, after clear-latch with it
    wire logic next_gate_en = (gate_reg | i_dimming_input_pin) & ~next_latched
        & ~i_ov_event;

    ////////////////////////////////////////////////////////////////
    // fault flags
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            shorted_load_flag <= 1'h0;
            open_load_flag <= 1'h0;
            overvoltage_flag <= 1'h0;
            overcurrent_flag <= 1'h0;
            ov_latched <= 1'h0;
        end
        else
        begin
            shorted_load_flag <= next_short;
            open_load_flag <= next_open;
            overvoltage_flag <= next_ov;
            overcurrent_flag <= next_oc;
            ov_latched <= next_latched;
        end
    end

    // writable control bits
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            overvoltage_latch_off_enable <= lcfl_pkg::lcfl_latch_reset;
            auto_calibration_select <= lcfl_pkg::lcfl_autocal_reset;
            gate_reg <= lcfl_pkg::lcfl_gate_reset;
        end
        else
        begin
            if (bus.wr_fault)
                overvoltage_latch_off_enable <= wr_latch;
            if (bus.wr_loop)
            begin
                auto_calibration_select <= wr_autocal;
                gate_reg <= wr_gate;
            end
        end
    end

    // start bit is a one-cycle pulse, hence it reads back as 0 after one clock
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            calibration_start <= lcfl_pkg::lcfl_calstart_reset;
        else
            calibration_start <= start_ok;
    end

    // outputs from flops
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_gate_enable <= 1'h0;
        else
            o_gate_enable <= next_gate_en;
    end

    assign o_auto_calibration_select = auto_calibration_select;
    assign o_calibration_start = calibration_start;

    ////////////////////////////////////////////////////////////////
    // register images; unlisted bits read zero
    always_comb
    begin
        bus.fault_image = 8'h00;
        bus.fault_image[lcfl_pkg::lcfl_fault_short_bit] = shorted_load_flag;
        bus.fault_image[lcfl_pkg::lcfl_fault_open_bit] = open_load_flag;
        bus.fault_image[lcfl_pkg::lcfl_fault_ov_bit] = overvoltage_flag;
        bus.fault_image[lcfl_pkg::lcfl_fault_mode_bit] = i_boost_mode;
        bus.fault_image[lcfl_pkg::lcfl_fault_latch_bit] = overvoltage_latch_off_enable;
        bus.fault_image[lcfl_pkg::lcfl_fault_oc_bit] = overcurrent_flag;
        bus.loop_image = 8'h00;
        bus.loop_image[lcfl_pkg::lcfl_loop_autocal_bit] = auto_calibration_select;
        bus.loop_image[lcfl_pkg::lcfl_loop_calstart_bit] = calibration_start;
        bus.loop_image[lcfl_pkg::lcfl_loop_gate_bit] = gate_reg;
    end
endmodule : lcfl_channel

`default_nettype wire

//--- logic/lcfl_pkg.sv
`default_nettype none

package lcfl_pkg;
    localparam int unsigned lcfl_channels = 2;
    localparam int unsigned lcfl_data_width = 8;
    // register select encoding on the access port: channel in bit 1, register in bit 0
    localparam logic [1:0] lcfl_addr_fault_ch0 = 2'h0;
    localparam logic [1:0] lcfl_addr_loop_ch0 = 2'h1;
    localparam logic [1:0] lcfl_addr_fault_ch1 = 2'h2;
    localparam logic [1:0] lcfl_addr_loop_ch1 = 2'h3;
    // fault register fields
    localparam int unsigned lcfl_fault_short_bit = 0;
    localparam int unsigned lcfl_fault_open_bit = 1;
    localparam int unsigned lcfl_fault_ov_bit = 2;
    localparam int unsigned lcfl_fault_mode_bit = 3;
    localparam int unsigned lcfl_fault_latch_bit = 4;
    localparam int unsigned lcfl_fault_oc_bit = 7;
    // loop-control register fields
    localparam int unsigned lcfl_loop_autocal_bit = 0;
    localparam int unsigned lcfl_loop_calstart_bit = 5;
    localparam int unsigned lcfl_loop_gate_bit = 7;
    // reset values
    localparam logic lcfl_latch_reset = 1'h0;
    localparam logic lcfl_autocal_reset = 1'h0;
    localparam logic lcfl_calstart_reset = 1'h0;
    localparam logic lcfl_gate_reset = 1'h0;
endpackage : lcfl_pkg

`default_nettype wire

//--- logic/lcfl_chan_if.sv
`default_nettype none

// per-channel access strobes and register images between top and channel
interface lcfl_chan_if;
    logic rd_fault;
    logic wr_fault;
    logic wr_loop;
    logic [7:0] wdata;
    logic [7:0] fault_image;
    logic [7:0] loop_image;
    modport top (output rd_fault, output wr_fault, output wr_loop, output wdata,
        input fault_image, input loop_image);
    modport chan (input rd_fault, input wr_fault, input wr_loop, input wdata,
        output fault_image, output loop_image);
endinterface : lcfl_chan_if

`default_nettype wire

//--- logic/lcfl_regs.sv
`default_nettype none

// two-channel fault and loop-control register bank behind a simple access port
module lcfl_regs
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic [1:0] i_short_event,
    input wire logic [1:0] i_open_event,
    input wire logic [1:0] i_ov_event,
    input wire logic [1:0] i_oc_event,
    input wire logic [1:0] i_boost_mode,
    input wire logic [1:0] i_dimming_input_pin,
    input wire logic i_clear_latch_command,
    output logic [1:0] o_gate_enable,
    output logic [1:0] o_auto_calibration_select,
    output logic [1:0] o_calibration_start
);
    lcfl_chan_if ch0 ();
    lcfl_chan_if ch1 ();

    ////////////////////////////////////////////////////////////////
    // address decode
    wire logic sel_f0 = (i_addr == lcfl_pkg::lcfl_addr_fault_ch0);
    wire logic sel_l0 = (i_addr == lcfl_pkg::lcfl_addr_loop_ch0);
    wire logic sel_f1 = (i_addr == lcfl_pkg::lcfl_addr_fault_ch1);
    wire logic sel_l1 = (i_addr == lcfl_pkg::lcfl_addr_loop_ch1);
    // a write wins if both strobes are high, so no read-clear then
    wire logic rd_ok = i_rd & ~i_wr;

    assign ch0.rd_fault = rd_ok & sel_f0;
    assign ch0.wr_fault = i_wr & sel_f0;
    assign ch0.wr_loop = i_wr & sel_l0;
    assign ch0.wdata = i_wdata;
    assign ch1.rd_fault = rd_ok & sel_f1;
    assign ch1.wr_fault = i_wr & sel_f1;
    assign ch1.wr_loop = i_wr & sel_l1;
    assign ch1.wdata = i_wdata;

    // read mux: image captured before the clear takes effect
    wire logic [7:0] rd_mux = sel_f0 ? ch0.fault_image
        : sel_l0 ? ch0.loop_image
        : sel_f1 ? ch1.fault_image
        : ch1.loop_image;

    ////////////////////////////////////////////////////////////////
    // channel instances
    lcfl_channel u_ch0
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .bus(ch0.chan),
        .i_short_event(i_short_event[0]),
        .i_open_event(i_open_event[0]),
        .i_ov_event(i_ov_event[0]),
        .i_oc_event(i_oc_event[0]),
        .i_boost_mode(i_boost_mode[0]),
        .i_dimming_input_pin(i_dimming_input_pin[0]),
        .i_clear_latch_command(i_clear_latch_command),
        .o_gate_enable(o_gate_enable[0]),
        .o_auto_calibration_select(o_auto_calibration_select[0]),
        .o_calibration_start(o_calibration_start[0])
    );

    lcfl_channel u_ch1
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .bus(ch1.chan),
        .i_short_event(i_short_event[1]),
        .i_open_event(i_open_event[1]),
        .i_ov_event(i_ov_event[1]),
        .i_oc_event(i_oc_event[1]),
        .i_boost_mode(i_boost_mode[1]),
        .i_dimming_input_pin(i_dimming_input_pin[1]),
        .i_clear_latch_command(i_clear_latch_command),
        .o_gate_enable(o_gate_enable[1]),
        .o_auto_calibration_select(o_auto_calibration_select[1]),
        .o_calibration_start(o_calibration_start[1])
    );

    ////////////////////////////////////////////////////////////////
    // registered read answer
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'h0;
        end
        else
        begin
            o_rvalid <= rd_ok;
            if (rd_ok)
                o_rdata <= rd_mux;
        end
    end
endmodule : lcfl_regs

`default_nettype wire

//--- verif/lcfl_regs_props.sv
`default_nettype none

// watches the register access port and the channel outputs of the bank
module lcfl_regs_props
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [1:0] i_short_event,
    input wire logic [1:0] i_open_event,
    input wire logic [1:0] i_ov_event,
    input wire logic [1:0] i_oc_event,
    input wire logic [1:0] i_boost_mode,
    input wire logic [1:0] i_dimming_input_pin,
    input wire logic i_clear_latch_command,
    input wire logic [1:0] o_gate_enable,
    input wire logic [1:0] o_auto_calibration_select,
    input wire logic [1:0] o_calibration_start
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // read of channel 0 fault image; a write in the same cycle wins
    wire rd0 = i_rd && !i_wr && i_addr == 2'h0;
    // same for the channel 1 fault image
    wire rd2 = i_rd && !i_wr && i_addr == 2'h2;
    a_rvalid_after_rd: assert property (i_rd && !i_wr |=> o_rvalid)
        else $error("read got no answer");
    a_no_spur_rvalid: assert property (!(i_rd && !i_wr) |=> !o_rvalid)
        else $error("answer without read");
    // event, one idle edge, then the read: the gap the host really leaves
    a_short_seen: assert property (i_short_event[0] ##1 !rd0 ##1 rd0 |=> o_rdata[0])
        else $error("short flag missing");
    a_open_seen: assert property (i_open_event[1] ##1 !rd2 ##1 rd2 |=> o_rdata[1])
        else $error("open flag missing");
    a_read_clears: assert property (rd0 && !i_short_event[0] ##1 !i_short_event[0] [*2]
        ##1 rd0 |=> !o_rdata[0])
        else $error("short flag kept after read");
    a_set_wins: assert property (rd0 && i_short_event[0] ##1 !rd0 [*2] ##1 rd0
        |=> o_rdata[0])
        else $error("event lost to read clear");
    a_mode_live: assert property (rd0 |=> o_rdata[3] == $past(i_boost_mode[0]))
        else $error("mode bit wrong");
    a_ov_gate_drop: assert property (i_ov_event[0] |=> !o_gate_enable[0])
        else $error("gate on during overvoltage");
    a_cal_cause: assert property (o_calibration_start[0]
        |-> $past(i_wr && i_addr == 2'h1 && i_wdata[0] && i_wdata[5]))
        else $error("start without legal write");
    a_autocal_wr: assert property (i_wr && i_addr == 2'h3
        |=> o_auto_calibration_select[1] == $past(i_wdata[0]))
        else $error("source select not written");
endmodule : lcfl_regs_props

`default_nettype wire

//--- verif/lcfl_host.sv
`default_nettype none

// host side of the access port; each strobe stands for exactly one edge
module lcfl_host
(
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    output logic o_rd,
    output logic o_wr,
    output logic [1:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        {o_rd, o_wr, o_addr, o_wdata} <= 12'h000;
    end
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {o_wr, o_addr, o_wdata} <= {1'h1, a, d};
        @(posedge i_clk);
        o_wr <= 1'h0;
    endtask : wr
    // data without its valid pulse comes back unknown so it never matches
    task rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        {o_rd, o_addr} <= {1'h1, a};
        @(posedge i_clk);
        o_rd <= 1'h0;
        @(posedge i_clk);
        d = (i_rvalid === 1'h1) ? i_rdata : 8'hxx;
    endtask : rd
endmodule : lcfl_host

`default_nettype wire

//--- verif/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'h0;
    logic i_resetn = 1'h0;
    logic [1:0] sh = 2'h0, op = 2'h0, ov = 2'h0, oc = 2'h0, bm = 2'h0, pin = 2'h0;
    logic clr = 1'h0;
    logic i_rd, i_wr, o_rvalid;
    logic [1:0] i_addr, o_gate_enable, o_auto_calibration_select, o_calibration_start;
    logic [7:0] i_wdata, o_rdata, r, ev;
    int n_fail = 0, checked = 0, seed = 32'h91b48464, ch;
    always #50 i_clk = ~i_clk;
    lcfl_host host (.i_clk(i_clk), .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_rd(i_rd),
        .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
    lcfl_regs DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_rd(i_rd), .i_wr(i_wr),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_short_event(sh), .i_open_event(op), .i_ov_event(ov), .i_oc_event(oc),
        .i_boost_mode(bm), .i_dimming_input_pin(pin), .i_clear_latch_command(clr),
        .o_gate_enable(o_gate_enable), .o_auto_calibration_select(o_auto_calibration_select),
        .o_calibration_start(o_calibration_start));
    ////////////////////////////////////////////////////////////////////////////////
    // expected fault image: latched flags, live mode, latch-off option
    function logic [7:0] exp_fault(input logic [7:0] e, input logic m, input logic l);
        return (e & 8'h87) | {3'h0, l, m, 3'h0};
    endfunction : exp_fault
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // one-edge event pulse on one channel, bits placed as in the fault image
    task fire(input int c, input logic [7:0] e);
        @(posedge i_clk);
        {sh[c], op[c], ov[c], oc[c]} <= {e[0], e[1], e[2], e[7]};
        @(posedge i_clk);
        {sh, op, ov, oc} <= 8'h00;
    endtask : fire
    task test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'h1;
        @(posedge i_clk);
        chk({2'h0, o_gate_enable, o_auto_calibration_select, o_calibration_start}, 8'h00,
            "reset outputs");
        // random faults, all four flags at once first; other channel must stay quiet
        for (int i = 0; i < 8; i++)
        begin
            ch = i % 2;
            ev = (i < 2) ? 8'h87 : 8'($random(seed));
            bm <= 2'($random(seed));
            fire(ch, ev);
            host.rd(2'(ch * 2), r);
            chk(r, exp_fault(ev, bm[ch], 1'h0), "flags");
            host.rd(2'(ch * 2), r);
            chk(r, exp_fault(8'h00, bm[ch], 1'h0), "flags after read");
            host.rd(2'((1 - ch) * 2), r);
            chk(r, exp_fault(8'h00, bm[1 - ch], 1'h0), "other channel");
        end
        // corner: event on the very edge that reads; the set must win
        fork
            host.rd(2'h0, r);
            fire(0, 8'h01);
        join
        chk(r, exp_fault(8'h00, bm[0], 1'h0), "read with event");
        host.rd(2'h0, r);
        chk(r, exp_fault(8'h01, bm[0], 1'h0), "event beats clear");
        $display("test faults done");
        host.wr(2'h1, 8'h21);
        #1 chk({4'h0, o_auto_calibration_select, o_calibration_start}, 8'h05, "cal on");
        @(posedge i_clk);
        #1 chk({6'h0, o_calibration_start}, 8'h00, "cal self clear");
        host.wr(2'h3, 8'h20);
        #1 chk({6'h0, o_calibration_start}, 8'h00, "cal refused");
        host.wr(2'h1, 8'h00);
        #1 chk({6'h0, o_auto_calibration_select}, 8'h00, "cal source");
        $display("test calibration done");
        // every mix of control bit and pin on both channels
        for (int k = 0; k < 16; k++)
        begin
            host.wr(2'h1, {k[0], 7'h00});
            host.wr(2'h3, {k[1], 7'h00});
            pin <= k[3:2];
            repeat (2) @(posedge i_clk);
            #1 chk({6'h0, o_gate_enable}, {6'h0, k[1:0] | k[3:2]}, "gate or");
        end
        pin <= 2'h0;
        $display("test gate done");
        host.wr(2'h2, 8'h10);
        host.wr(2'h1, 8'h80);
        fire(1, 8'h04);
        fire(0, 8'h04);
        repeat (3) @(posedge i_clk);
        #1 chk({6'h0, o_gate_enable}, 8'h01, "latched gate");
        for (int j = 0; j < 2; j++)
        begin
            host.rd(2'h2, r);
            chk(r, exp_fault(8'h04, bm[1], 1'h1), "ov kept");
        end
        @(posedge i_clk);
        clr <= 1'h1;
        @(posedge i_clk);
        clr <= 1'h0;
        host.rd(2'h2, r);
        chk(r, exp_fault(8'h00, bm[1], 1'h1), "ov after clear");
        host.wr(2'h3, 8'h80);
        repeat (2) @(posedge i_clk);
        #1 chk({6'h0, o_gate_enable}, 8'h03, "gate restart");
        $display("test latch done");
        // reset in mid-run with flags pending and latch-off set on channel 1
        fire(1, 8'h87);
        i_resetn <= 1'h0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'h1;
        host.rd(2'h2, r);
        chk(r, exp_fault(8'h00, bm[1], 1'h0), "reset clears");
        chk({6'h0, o_gate_enable}, 8'h00, "gate after reset");
        $display("test reset done");
        test_done();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #2000000;
        n_fail++;
        test_done();
    end
endmodule : tb

bind lcfl_regs lcfl_regs_props u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_rd(i_rd),
    .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_short_event(i_short_event), .i_open_event(i_open_event), .i_ov_event(i_ov_event),
    .i_oc_event(i_oc_event), .i_boost_mode(i_boost_mode),
    .i_dimming_input_pin(i_dimming_input_pin), .i_clear_latch_command(i_clear_latch_command),
    .o_gate_enable(o_gate_enable), .o_auto_calibration_select(o_auto_calibration_select),
    .o_calibration_start(o_calibration_start));

`default_nettype wire
